/* File: hdl/ebc_bus_ctrl.sv */
// External bus control of a 16-bit processor: bus sequencer, run/stop,
// bus release, slow-device wait, branch-on-external, interrupt pins.
// Assumes all pins synchronous to i_clk_sys; core issues one op at a time.
`timescale 1ns/100ps
module ebc_bus_ctrl
	import ebc_pkg::*;
(
	input wire logic i_clk_sys, // System clock
	input wire logic i_srst, // Sync reset, high
	input wire logic i_stop_start_toggle, // Run/stop control
	input wire logic i_master_sync_n, // Power-up sync, low
	input wire logic i_bus_release_request_n, // Bus request, low
	input wire logic i_slow_data_ready, // Low requests wait
	input wire logic i_irq_n, // Interrupt request
	input wire logic i_maskable_irq_n, // Maskable interrupt
	input wire logic i_ext_cond_return, // Selected condition
	input wire logic [15:0] i_data_lines, // Data bus in
	input wire logic i_pc_hold_trap, // Hold/trap pin in
	input wire logic i_req_valid, // Core bus request
	input wire ebc_req_t i_req, // Core request
	input wire logic i_insn_end, // Instruction boundary
	input wire logic i_int_enable, // Maskable enabled
	input wire logic i_fetch, // Request is fetch
	input wire logic i_branch_on_external, // External branch
	input wire logic [3:0] i_cond_code, // Branch condition
	input wire logic i_end_of_service, // Terminate interrupt
	input wire logic i_software_interrupt, // Software int
	output logic [15:0] o_data_lines, // Data bus out
	output logic o_data_oe, // Data bus drive
	output ebc_code_t o_bus_code, // Bus control lines
	output logic o_bus_released_n, // Bus acknowledge, low
	output logic o_halted, // Stopped indicator
	output logic [3:0] o_ext_cond_select, // Condition select
	output logic o_branch_taken, // Branch decision
	output logic o_branch_valid, // Decision pulse
	output logic o_pc_hold_trap, // Hold/trap pin out
	output logic o_pc_hold_trap_oe, // Hold/trap drive
	output logic o_end_of_service_pulse, // Terminate pulse
	output logic o_pc_inhibit, // Skip PC increment
	output logic o_int_take, // Start interrupt service
	output logic o_req_ready, // Request accepted
	output logic [15:0] o_rdata, // Read data to core
	output logic o_rdata_valid // Read data pulse
);
	typedef enum {
		ST_SYNC, ST_IDLE, ST_ADDR, ST_WAITCHK, ST_WAIT,
		ST_DATA, ST_STROBE, ST_RELEASED
	} ebc_state_t;

	ebc_state_t state_q;
	ebc_state_t state_d;
	ebc_req_t req_q;
	logic [7:0] slot_cnt_q;
	logic [31:0] wait_cnt_q;
	logic toggle_prev_q;
	logic running_q;
	logic [15:0] data_q;
	logic data_oe_q;
	ebc_code_t code_q;
	logic released_n_q;
	logic [3:0] cond_q;
	logic br_taken_q;
	logic br_valid_q;
	logic [7:0] br_cnt_q;
	logic [7:0] eos_cnt_q;
	logic [7:0] trap_cnt_q;
	logic pc_inh_q;
	logic int_take_q;
	logic irq_pend_q;
	logic ready_q;
	logic [15:0] rdata_q;
	logic rvalid_q;

	wire slot_end = (slot_cnt_q == 8'(SLOT_CYC - 1));
	wire mcyc_end = (slot_cnt_q == 8'(MICROCYCLE_CYC - 1));
	wire toggle_fall = toggle_prev_q & ~i_stop_start_toggle;
	wire bus_req = ~i_bus_release_request_n;
	wire start_ok = running_q & i_req_valid & ~bus_req;
	wire is_write = (req_q.op == EBC_OP_WRITE);
	wire irq_any = ~i_irq_n | (~i_maskable_irq_n & i_int_enable);
	wire wait_tmo = (wait_cnt_q == 32'(WAIT_MAX_CYC - 1));
	// The accepting edge already drives the address, so it must see the
	// incoming request rather than the one still held from before
	wire ebc_req_t req_cur = (state_q == ST_IDLE) ? i_req : req_q;
	wire [2:0] addr_code = (req_cur.op == EBC_OP_IND_READ) ? BUS_IND_ADDR :
		BUS_ADDR_LATCH;
	wire accept = (state_q == ST_IDLE) && start_ok;
	wire addr_oe = (req_cur.op != EBC_OP_INT_ACK) &&
		(req_cur.op != EBC_OP_IND_READ);
	wire read_done = (state_q == ST_DATA) && mcyc_end && !is_write;
	wire int_ack_addr = (state_q == ST_ADDR) &&
		(req_q.op == EBC_OP_INT_ACK);
	wire lines_released = (state_q == ST_RELEASED) && !data_oe_q;
	wire take_now = i_insn_end && (irq_pend_q || irq_any);
	wire [2:0] data_code = (req_q.op == EBC_OP_INT_ACK) ? BUS_INT_VEC :
		is_write ? BUS_WRITE : BUS_READ;

	// Slot counter runs in whole microcycles so waits add full microcycles
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_SYNC: begin
				if (~i_master_sync_n)
					state_d = ST_SYNC;
				else
					state_d = ST_IDLE;
			end
			ST_IDLE: begin
				// Bus request wins over a waiting core request
				if (bus_req)
					state_d = ST_RELEASED;
				else if (start_ok)
					state_d = ST_ADDR;
			end
			ST_ADDR: begin
				if (mcyc_end) begin
					state_d = ST_WAITCHK;
				end
			end
			ST_WAITCHK: begin
				// Whether to wait is decided only here, end of first slot
				if (slot_end)
					state_d = i_slow_data_ready ? ST_DATA : ST_WAIT;
			end
			ST_WAIT: begin
				// Release may come at any time; resume on microcycle edge
				if (mcyc_end && (i_slow_data_ready || wait_tmo))
					state_d = ST_DATA;
			end
			ST_DATA: begin
				if (mcyc_end) begin
					state_d = is_write ? ST_STROBE : ST_IDLE;
				end
			end
			ST_STROBE: begin
				if (mcyc_end) begin
					state_d = ST_IDLE;
				end
			end
			ST_RELEASED: begin
				if (!bus_req) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || (~i_master_sync_n && state_q != ST_SYNC)) begin
			state_q <= ST_SYNC;
			slot_cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			// Restart on every state change so each phase counts from zero
			if (state_d != state_q || mcyc_end || state_q == ST_IDLE) begin
				slot_cnt_q <= 8'h00;
			end else begin
				slot_cnt_q <= slot_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		// Saturates at the limit so a stuck device cannot hang the bus
		if (i_srst || state_q != ST_WAIT) begin
			wait_cnt_q <= 32'h00000000;
		end else if (!wait_tmo) begin
			wait_cnt_q <= wait_cnt_q + 32'h00000001;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			toggle_prev_q <= 1'b1;
			running_q <= 1'b0;
		end else begin
			toggle_prev_q <= i_stop_start_toggle;
			// Previous sample resets high: a pin held low out of reset gives one falling edge
			if (toggle_fall) begin
				running_q <= ~running_q;
			end
		end
	end

	// Bus driver: one 16-bit word address, no separate I/O space
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			req_q <= '0;
			data_q <= DATA_RESET;
			data_oe_q <= 1'b0;
			code_q <= BUS_IDLE;
			released_n_q <= 1'b1;
		end else begin
			if (accept) begin
				req_q <= i_req;
			end
			case (state_d)
				ST_ADDR: begin
					code_q <= addr_code;
					data_q <= req_cur.addr;
					data_oe_q <= addr_oe;
				end
				// Address code holds through the check slot and waits
				ST_WAITCHK, ST_WAIT: begin
				end
				ST_DATA: begin
					code_q <= data_code;
					data_q <= req_q.wdata;
					data_oe_q <= is_write;
				end
				ST_STROBE: begin
					code_q <= BUS_WR_STROBE;
					data_oe_q <= 1'b1;
				end
				default: begin
					code_q <= BUS_IDLE;
					data_oe_q <= 1'b0;
				end
			endcase
			if (int_ack_addr) begin
				code_q <= BUS_INT_ACK;
			end
			// Acknowledge only after lines have been idle a cycle
			released_n_q <= ~lines_released;
		end
	end

	// Core side handshake and read capture, apart from the pin drivers
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ready_q <= 1'b0;
			rdata_q <= DATA_RESET;
			rvalid_q <= 1'b0;
			pc_inh_q <= 1'b0;
		end else begin
			ready_q <= accept;
			rvalid_q <= read_done;
			pc_inh_q <= read_done & i_fetch & i_pc_hold_trap;
			if (read_done) begin
				rdata_q <= i_data_lines;
			end
		end
	end

	// External branch: hold select, decide after settle time
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			cond_q <= 4'h0;
			br_cnt_q <= 8'h00;
			br_taken_q <= 1'b0;
			br_valid_q <= 1'b0;
		end else begin
			br_valid_q <= 1'b0;
			if (i_branch_on_external && br_cnt_q == 8'h00) begin
				cond_q <= i_cond_code;
				br_cnt_q <= 8'(SLOT_CYC * 4);
			end else if (br_cnt_q != 8'h00) begin
				br_cnt_q <= br_cnt_q - 8'h01;
				if (br_cnt_q == 8'h01) begin
					br_taken_q <= i_ext_cond_return;
					br_valid_q <= 1'b1;
				end
			end
		end
	end

	// Fixed-width output pulses; a new request restarts the count
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			eos_cnt_q <= 8'h00;
			trap_cnt_q <= 8'h00;
		end else begin
			if (i_end_of_service) begin
				eos_cnt_q <= 8'(PULSE_CYC);
			end else if (eos_cnt_q != 8'h00) begin
				eos_cnt_q <= eos_cnt_q - 8'h01;
			end
			if (i_software_interrupt) begin
				trap_cnt_q <= 8'(PULSE_CYC);
			end else if (trap_cnt_q != 8'h00) begin
				trap_cnt_q <= trap_cnt_q - 8'h01;
			end
		end
	end

	// Interrupt taken only at an instruction boundary; a request seen
	// mid-instruction is remembered until then
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			irq_pend_q <= 1'b0;
			int_take_q <= 1'b0;
		end else begin
			int_take_q <= take_now;
			if (take_now) begin
				irq_pend_q <= 1'b0;
			end else if (irq_any) begin
				irq_pend_q <= 1'b1;
			end
		end
	end

	assign o_data_lines = data_q;
	assign o_data_oe = data_oe_q;
	assign o_bus_code = code_q;
	assign o_bus_released_n = released_n_q;
	assign o_halted = ~running_q;
	assign o_ext_cond_select = cond_q;
	assign o_branch_taken = br_taken_q;
	assign o_branch_valid = br_valid_q;
	assign o_pc_hold_trap = (trap_cnt_q != 8'h00);
	assign o_pc_hold_trap_oe = (trap_cnt_q != 8'h00);
	assign o_end_of_service_pulse = (eos_cnt_q != 8'h00);
	assign o_pc_inhibit = pc_inh_q;
	assign o_int_take = int_take_q;
	assign o_req_ready = ready_q;
	assign o_rdata = rdata_q;
	assign o_rdata_valid = rvalid_q;
endmodule : ebc_bus_ctrl

/* File: hdl/ebc_pkg.sv */
// Package for the external bus control block: bus codes, timing, carriers.
// Assumes a single 250 MHz system clock.
package ebc_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int MICROCYCLE_NS = 600;
	localparam int MICROCYCLE_CYC = (MICROCYCLE_NS * 1000) / CLK_PERIOD_PS;
	localparam int SLOT_CYC = MICROCYCLE_CYC / 4;
	localparam int WAIT_MAX_US = 40;
	localparam int WAIT_MAX_CYC = (WAIT_MAX_US * 1000000) / CLK_PERIOD_PS;
	localparam int PULSE_NS = 300;
	localparam int PULSE_CYC = (PULSE_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [2:0] BUS_IDLE = 3'h0;
	localparam logic [2:0] BUS_INT_VEC = 3'h1;
	localparam logic [2:0] BUS_IND_ADDR = 3'h2;
	localparam logic [2:0] BUS_READ = 3'h3;
	localparam logic [2:0] BUS_ADDR_LATCH = 3'h4;
	localparam logic [2:0] BUS_WR_STROBE = 3'h5;
	localparam logic [2:0] BUS_WRITE = 3'h6;
	localparam logic [2:0] BUS_INT_ACK = 3'h7;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	typedef enum logic [2:0] {
		EBC_OP_NONE,
		EBC_OP_READ,
		EBC_OP_WRITE,
		EBC_OP_IND_READ,
		EBC_OP_INT_ACK
	} ebc_op_t;

	typedef struct packed {
		ebc_op_t op;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ebc_req_t;

	typedef struct packed {
		logic bus_direction;
		logic bus_ctrl_1;
		logic bus_ctrl_2;
	} ebc_code_t;
endpackage : ebc_pkg

/* File: bench/ebc_bus_ctrl_monitor.sv */
// Port-level checker for the external bus control block.
// Bound into every ebc_bus_ctrl; sees only its top-level ports.
`timescale 1ns/100ps
module ebc_bus_ctrl_chk
	import ebc_pkg::*;
(
	input wire logic i_clk_sys, // Clock
	input wire logic i_srst, // Reset
	input wire logic i_stop_start_toggle, // Run/stop
	input wire logic i_master_sync_n, // Sync
	input wire logic i_bus_release_request_n, // Bus request
	input wire logic i_slow_data_ready, // Wait line
	input wire logic i_branch_on_external, // Branch
	input wire logic [3:0] i_cond_code, // Condition
	input wire logic i_end_of_service, // Terminate
	input wire logic i_software_interrupt, // Soft int
	input wire logic o_data_oe, // Bus drive
	input wire ebc_code_t o_bus_code, // Bus code
	input wire logic o_bus_released_n, // Ack
	input wire logic o_halted, // Halted
	input wire logic [3:0] o_ext_cond_select, // Select
	input wire logic o_pc_hold_trap, // Trap out
	input wire logic o_pc_hold_trap_oe, // Trap drive
	input wire logic o_end_of_service_pulse // Terminate out
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	sequence s_addr_cycle;
		o_bus_code == BUS_ADDR_LATCH;
	endsequence
	sequence s_trap_drive;
		o_pc_hold_trap_oe && o_pc_hold_trap;
	endsequence
	a_halt_toggle: assert property ($fell(i_stop_start_toggle) &&
		i_master_sync_n |-> ##[1:2] $changed(o_halted)) else $error("no toggle");
	a_drive_dir: assert property (o_data_oe |->
		o_bus_code.bus_direction) else $error("drive on input code");
	a_release_float: assert property (!o_bus_released_n |->
		!o_data_oe && o_bus_code == BUS_IDLE) else $error("bus not floated");
	a_ack_needs_req: assert property (!o_bus_released_n |->
		!$past(i_bus_release_request_n, 2)) else $error("ack without request");
	a_eos_pulse: assert property ($rose(i_end_of_service) |->
		##[1:2] o_end_of_service_pulse) else $error("no terminate pulse");
	a_trap_pulse: assert property ($rose(i_software_interrupt) |->
		##[1:2] s_trap_drive) else $error("no trap pulse");
	a_cond_select: assert property (i_branch_on_external |=>
		o_ext_cond_select == $past(i_cond_code)) else $error("bad select");
	a_wait_hold: assert property (s_addr_cycle ##0 !i_slow_data_ready
		|=> o_bus_code != BUS_READ) else $error("wait ignored");
endmodule : ebc_bus_ctrl_chk

bind ebc_bus_ctrl ebc_bus_ctrl_chk u_chk (.i_clk_sys, .i_srst,
	.i_stop_start_toggle, .i_master_sync_n, .i_bus_release_request_n,
	.i_slow_data_ready, .i_branch_on_external, .i_cond_code,
	.i_end_of_service, .i_software_interrupt, .o_data_oe, .o_bus_code,
	.o_bus_released_n, .o_halted, .o_ext_cond_select, .o_pc_hold_trap,
	.o_pc_hold_trap_oe, .o_end_of_service_pulse);

/* File: bench/ebc_mem_model.sv */
// Memory on the far side of the data bus, with an optional slow wait.
// Assumes it is clocked by the processor clock; acts on falling edges.
`timescale 1ns/100ps
module ebc_mem_model
	import ebc_pkg::*;
(
	input wire logic i_clk_sys, // Clock
	input wire logic i_stall, // Ask for a wait
	input wire ebc_code_t i_bus_code, // Bus state
	input wire logic i_bus_oe, // Processor drives
	input wire logic [15:0] i_bus_out, // Processor data
	output logic [15:0] o_bus_in, // Memory side of bus
	output logic o_ready // Slow data ready
);
	logic [15:0] addr_q = 16'h0000;
	logic waited_q = 1'b0;
	int wait_cnt = 0;
	initial o_bus_in = 16'h0000;
	assign o_ready = (wait_cnt == 0);
	always @(negedge i_clk_sys) begin
		if (i_bus_code == BUS_ADDR_LATCH && i_bus_oe) begin
			addr_q <= i_bus_out;
		end
		// Undriven bus toggles so a stale value cannot pass
		o_bus_in <= (i_bus_code == BUS_READ) ? addr_q ^ 16'h5A5A : ~o_bus_in;
		if (wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
		end else if (i_stall && !waited_q && i_bus_code == BUS_ADDR_LATCH) begin
			wait_cnt <= 333;
		end
		waited_q <= (i_bus_code == BUS_READ) ? 1'b0 : waited_q | (wait_cnt > 0);
	end
endmodule : ebc_mem_model

/* File: bench/ebc_bus_ctrl_bench.sv */
// Self-checking bench for the external bus control block.
// Inputs change at falling edges; the memory model answers reads.
`timescale 1ns/100ps
module ebc_bus_ctrl_bench
	import ebc_pkg::*;
;
	logic i_clk_sys = 1'b0, i_srst = 1'b1, i_stop_start_toggle = 1'b1;
	logic i_master_sync_n = 1'b0, i_bus_release_request_n = 1'b1;
	logic i_ext_cond_return = 1'b0, i_pc_hold_trap = 1'b0, stall = 1'b0;
	logic i_req_valid = 1'b0, i_fetch = 1'b0, i_branch_on_external = 1'b0;
	logic i_end_of_service = 1'b0, i_software_interrupt = 1'b0;
	logic i_irq_n = 1'b1, i_maskable_irq_n = 1'b1, i_insn_end = 1'b0;
	logic i_int_enable = 1'b0;
	logic [3:0] i_cond_code = 4'h0;
	ebc_req_t i_req = '0;
	logic [15:0] i_data_lines, o_data_lines, o_rdata, mem_bus;
	logic i_slow_data_ready, o_data_oe, o_bus_released_n, o_halted;
	ebc_code_t o_bus_code;
	logic [3:0] o_ext_cond_select;
	logic o_branch_taken, o_branch_valid, o_pc_hold_trap, o_pc_hold_trap_oe;
	logic o_end_of_service_pulse, o_pc_inhibit, o_int_take, o_req_ready;
	logic o_rdata_valid;
	int err_total = 0, check_count = 0, rdy_cnt = 0;
	assign i_data_lines = o_data_oe ? o_data_lines : mem_bus;
	ebc_bus_ctrl dut (.i_clk_sys, .i_srst, .i_stop_start_toggle,
		.i_master_sync_n, .i_bus_release_request_n, .i_slow_data_ready,
		.i_irq_n, .i_maskable_irq_n, .i_ext_cond_return,
		.i_data_lines, .i_pc_hold_trap, .i_req_valid, .i_req,
		.i_insn_end, .i_int_enable, .i_fetch, .i_branch_on_external,
		.i_cond_code, .i_end_of_service, .i_software_interrupt, .o_data_lines,
		.o_data_oe, .o_bus_code, .o_bus_released_n, .o_halted,
		.o_ext_cond_select, .o_branch_taken, .o_branch_valid, .o_pc_hold_trap,
		.o_pc_hold_trap_oe, .o_end_of_service_pulse, .o_pc_inhibit,
		.o_int_take, .o_req_ready, .o_rdata, .o_rdata_valid);
	ebc_mem_model mem (.i_clk_sys, .i_stall(stall), .i_bus_code(o_bus_code),
		.i_bus_oe(o_data_oe), .i_bus_out(o_data_lines), .o_bus_in(mem_bus),
		.o_ready(i_slow_data_ready));
	always #2 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) if (o_req_ready === 1'b1) rdy_cnt++;
	task automatic fail(input string what);
		err_total++;
		$display("MISMATCH t=%0t %s", $time, what);
	endtask : fail
	task automatic chk_word(input logic [15:0] got, exp, input string what);
		check_count++;
		if (got !== exp) fail(what);
	endtask : chk_word
	task automatic chk_bit(input logic got, exp, input string what);
		check_count++;
		if (got !== exp) fail(what);
	endtask : chk_bit
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask : cyc
	task automatic bus_op(input ebc_op_t op, input logic [15:0] a, wd,
		output int n, output logic [15:0] wr, output logic inh);
		n = 0;
		wr = 16'h0000;
		inh = 1'b0;
		i_req = '{op: op, addr: a, wdata: wd};
		i_req_valid = 1'b1;
		while (o_req_ready !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk_bit(o_req_ready, 1'b1, "request not taken");
		i_req_valid = 1'b0;
		n = 0;
		while (n < 2000 && (op == EBC_OP_READ ? o_rdata_valid !== 1'b1
			: o_bus_code !== BUS_IDLE)) begin
			if (o_bus_code === BUS_WRITE && o_data_oe === 1'b1) wr = o_data_lines;
			inh |= o_pc_inhibit;
			cyc(1);
			n++;
		end
		inh |= o_pc_inhibit;
	endtask : bus_op
	task automatic t_start;
		chk_bit(o_halted, 1'b1, "running after reset");
		chk_bit(o_bus_released_n, 1'b1, "ack after reset");
		i_req_valid = 1'b1;
		cyc(20);
		i_req_valid = 1'b0;
		chk_word(16'(rdy_cnt), 16'h0000, "taken while stopped");
		i_master_sync_n = 1'b1;
		cyc(2);
		i_stop_start_toggle = 1'b0;
		cyc(3);
		chk_bit(o_halted, 1'b0, "falling edge ignored");
		i_stop_start_toggle = 1'b1;
		cyc(3);
		chk_bit(o_halted, 1'b0, "rising edge acted on");
	endtask : t_start
	task automatic t_reads;
		int n0, n1;
		logic [15:0] wr;
		logic inh;
		i_fetch = 1'b1;
		bus_op(EBC_OP_READ, 16'h1234, 16'h0000, n0, wr, inh);
		chk_word(o_rdata, 16'h486E, "plain read");
		chk_bit(inh, 1'b0, "inhibit without hold");
		stall = 1'b1;
		i_pc_hold_trap = 1'b1;
		bus_op(EBC_OP_READ, 16'hFFFF, 16'h0000, n1, wr, inh);
		chk_word(o_rdata, 16'hA5A5, "stretched read");
		chk_bit(inh, 1'b1, "no inhibit with hold");
		chk_bit(n1 > n0 && (n1 - n0) % MICROCYCLE_CYC == 0, 1'b1, "wait");
		stall = 1'b0;
		i_pc_hold_trap = 1'b0;
		i_fetch = 1'b0;
		bus_op(EBC_OP_WRITE, 16'h0000, 16'hC3A5, n0, wr, inh);
		chk_word(wr, 16'hC3A5, "write data");
	endtask : t_reads
	task automatic t_release;
		int n;
		n = 0;
		i_bus_release_request_n = 1'b0;
		while (o_bus_released_n !== 1'b0 && n < 20) begin
			cyc(1);
			n++;
		end
		chk_bit(o_bus_released_n, 1'b0, "bus kept");
		rdy_cnt = 0;
		i_req_valid = 1'b1;
		cyc(30);
		i_req_valid = 1'b0;
		chk_word(16'(rdy_cnt), 16'h0000, "taken while released");
		i_bus_release_request_n = 1'b1;
		cyc(5);
		chk_bit(o_bus_released_n, 1'b1, "bus not regained");
	endtask : t_release
	task automatic t_branch;
		int n;
		for (int c = 0; c < 16; c++) begin
			i_cond_code = 4'(c);
			i_ext_cond_return = c[0] ^ c[3];
			i_branch_on_external = 1'b1;
			cyc(1);
			i_branch_on_external = 1'b0;
			n = 0;
			while (o_branch_valid !== 1'b1 && n < 300) begin
				cyc(1);
				n++;
			end
			chk_bit(o_branch_valid, 1'b1, "no decision");
			chk_word(16'(o_ext_cond_select), 16'(c), "select");
			chk_bit(o_branch_taken, c[0] ^ c[3], "decision");
		end
	endtask : t_branch
	task automatic t_irq;
		i_irq_n = 1'b0;
		cyc(3);
		chk_bit(o_int_take, 1'b0, "taken mid-instruction");
		i_insn_end = 1'b1;
		cyc(1);
		i_insn_end = 1'b0;
		i_irq_n = 1'b1;
		chk_bit(o_int_take, 1'b1, "not taken at boundary");
		i_maskable_irq_n = 1'b0;
		cyc(1);
		chk_bit(o_int_take, 1'b0, "take not a pulse");
		i_insn_end = 1'b1;
		cyc(1);
		i_insn_end = 1'b0;
		i_maskable_irq_n = 1'b1;
		chk_bit(o_int_take, 1'b0, "masked request taken");
	endtask : t_irq
	task automatic t_pulses;
		int n;
		for (int k = 0; k < 2; k++) begin
			i_end_of_service = (k == 0);
			i_software_interrupt = (k == 1);
			cyc(1);
			i_end_of_service = 1'b0;
			i_software_interrupt = 1'b0;
			n = 0;
			while ((k ? o_pc_hold_trap_oe : o_end_of_service_pulse) !== 1'b1
				&& n < 4) begin
				cyc(1);
				n++;
			end
			n = 0;
			while ((k ? o_pc_hold_trap_oe : o_end_of_service_pulse) === 1'b1
				&& n < 500) begin
				cyc(1);
				n++;
			end
			chk_word(16'(n), 16'(PULSE_CYC), "pulse length");
		end
		i_stop_start_toggle = 1'b0;
		cyc(3);
		chk_bit(o_halted, 1'b1, "not stopped");
	endtask : t_pulses
	initial begin
		cyc(8);
		i_srst = 1'b0;
		cyc(1);
		t_start;
		t_reads;
		t_release;
		t_branch;
		t_irq;
		t_pulses;
		report_and_stop;
	end
	initial begin
		#(20000 * 4);
		fail("watchdog expired");
		report_and_stop;
	end
endmodule : ebc_bus_ctrl_bench
